// ---- design/conv_consts.svh ----
// Offsets, field positions, reset values and timing counts of the converter
`ifndef CONV_CONSTS_SVH
`define CONV_CONSTS_SVH

`define MCLK_NS 40
`define CYC_UP(ns) (((ns) + `MCLK_NS - 1) / `MCLK_NS)
`define CYC_DN(ns) ((ns) / `MCLK_NS)

`define OSC_NS 400
`define OSC_CYC `CYC_DN(`OSC_NS)
`define GATE_DELAY_NS 1600
`define GATE_DELAY_CYC `CYC_UP(`GATE_DELAY_NS)
`define RING_PULSE_NS 400
`define RING_PULSE_CYC `CYC_UP(`RING_PULSE_NS)
`define DATA_GAP_NS 2400
`define DATA_GAP_CYC `CYC_UP(`DATA_GAP_NS)
`define CLOCK_GAP_NS 2800
`define CLOCK_GAP_CYC `CYC_UP(`CLOCK_GAP_NS)
`define ZERO_WIN_NS 800
`define ZERO_WIN_CYC `CYC_UP(`ZERO_WIN_NS)

`define ADDR_CTRL 4'h0
`define ADDR_DATA 4'h4
`define ADDR_STAT 4'h8

`define CTRL_READ 0
`define CTRL_WRITE 1
`define CTRL_MARKER 2
`define DATA_PARITY 8

`define ST_FOUND 0
`define ST_TAKEN 1
`define ST_PARERR 2
`define ST_DGAP 3
`define ST_CGAP 4
`define ST_ZERO 5
`define ST_ONES 6
`define ST_RCG 7
`define ST_WCG 8

`define RING_START 3'h5
`define MARKER_CLOCK_MASK 8'hf0
`define CTRL_RESET 3'h0

`endif

// ---- design/conv_pkg.sv ----
// Types shared by the converter modules
package conv_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {TRK_IDLE, TRK_RESET, TRK_WAIT, TRK_RUN} trk_state_t;
    typedef enum logic {WIN_CLOCK, WIN_DATA} window_t;
endpackage

// ---- design/disk_converter.sv ----
// Serial/parallel converter between the control store and a serial disk drive
//
// Contract
// - With read gate on, incoming pulses are deserialized.
// - Read gate plus marker search hunts a marker; marker found flag then sets.
// - With write gate on, clock and data pulses go to the drive.
// - Write gate plus marker search writes a marker byte with clocks missing.
// - Write oscillator and X/Y phase triggers run all the time.
// - Write gate rise delays write clock gate 1600 ns and drops the tracker.
// - 400 ns pulse with both clock gates off resets rings, secondary to 5.
// - Phase Y permit latch makes the first ring advance a phase X step.
// - Write gate, write clock gate, no Y permit step the 4-position counter.
// - Each byte taken for writing has its parity checked.
// - Primary and secondary rings sequence the shared data register both ways; only the primary ring indexes it, deltaPos_q is never read.
// - Write clock pulses interleave with data pulses, double frequency.
// - Tracker runs from its start gate, except writing or its reset interval.
// - Tracker alternates clock and data windows to separate pulses.
// - Data gap rises after 2.4 us with no separated data pulse.
// - Clock gap rises after 2.8 us with no separated clock pulse.
// - Zeros detector: one pulse per 800 ns is zero, two is ones reset.
// - Ones reset holds until the next window judged zero.
// - Read gate rise holds tracker latches 1600 ns; next pulse starts it.
// - Marker flag sets at ring position 0 only once search is over.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "conv_consts.svh"
module disk_converter
    import conv_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [31:0] rdData_q,
    input wire logic readPulsePin,
    output logic writePulse_q,
    output logic writeEnable_q
);
    // Software control and data holding
    logic [2:0] ctrl_q;
    logic [8:0] hold_q;
    byte_t fdr_q;
    byte_t readByte_q;
    logic found_q, taken_q, parErr_q;
    // Write timing
    logic [3:0] oscCnt_q;
    logic writeTrig_q;
    logic wrGatePrev_q;
    logic [5:0] gateDelay_q;
    logic writeClockGate_q;
    logic [1:0] posCounter_q;
    // Rings
    logic [2:0] ringPos_q, deltaPos_q;
    logic ringLive_q, allowY_q;
    logic ringCondPrev_q;
    logic [3:0] ringPulseCnt_q;
    // Read side
    logic pinMeta_q, pinSync_q, pinPrev_q;
    trk_state_t trk_q;
    logic [5:0] trkReset_q;
    logic [3:0] phase_q;
    window_t win_q;
    logic dataSeen_q;
    logic readClockGate_q, dataGood_q, searchActive_q, markerSeen_q;
    logic [4:0] zwinCnt_q;
    logic [1:0] zpulses_q;
    logic zeroCount_q, onesReset_q;
    logic dataGap, clockGap;

    // Decoded controls
    wire logic readGate = ctrl_q[`CTRL_READ];
    wire logic writeGate = ctrl_q[`CTRL_WRITE];
    wire logic markerSearch = ctrl_q[`CTRL_MARKER];
    wire logic wrCtrl = wrStrobe && addr == `ADDR_CTRL;
    wire logic wrDat = wrStrobe && addr == `ADDR_DATA;
    wire logic wrStat = wrStrobe && addr == `ADDR_STAT;

    // Free-running oscillator taps and the write gate edge
    wire logic oscTick = oscCnt_q == 4'(`OSC_CYC - 1);
    wire logic phaseX = oscTick && !writeTrig_q;
    wire logic phaseY = oscTick && writeTrig_q;
    wire logic wrGateRise = writeGate && !wrGatePrev_q;
    wire logic writing = writeGate && writeClockGate_q;

    // Tracker phase and pulse separation
    wire logic rdEdge = pinSync_q && !pinPrev_q;
    wire logic trkRun = trk_q == TRK_RUN;
    wire logic phWrap = phase_q == 4'(`OSC_CYC - 1);
    wire logic sepClock = rdEdge && trkRun && win_q == WIN_CLOCK;
    wire logic sepData = rdEdge && trkRun && win_q == WIN_DATA;
    wire logic cellEnd = trkRun && phWrap && win_q == WIN_DATA;

    // Ring advance sources, write and read share the rings
    wire logic advX = (writing && phaseX) || (readClockGate_q && cellEnd);
    wire logic advY = writing && phaseY && allowY_q;
    wire logic [2:0] nextPos = ringLive_q ? ringPos_q + 3'h1 : `RING_START;
    wire logic byteEdge = advX && nextPos == 3'h0;
    wire logic ringCond = !readClockGate_q && !writeClockGate_q;
    wire logic ringReset = ringCond || ringPulseCnt_q != 4'h0;
    wire logic [7:0] clockMask = `MARKER_CLOCK_MASK;
    wire logic clkAllowed = !markerSearch || clockMask[nextPos];

    // Register bus write side
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_q <= `CTRL_RESET;
            hold_q <= 9'h000;
        end else begin
            if (wrCtrl)
                ctrl_q <= wrData[2:0];
            if (wrDat)
                hold_q <= wrData[8:0];
        end
    end

    // Sticky flags: a hardware set beats a same-cycle clear
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            found_q <= 1'b0;
            taken_q <= 1'b0;
            parErr_q <= 1'b0;
        end else begin
            if (readClockGate_q && byteEdge && !writing && !searchActive_q)
                found_q <= 1'b1;
            else if (wrStat && wrData[`ST_FOUND])
                found_q <= 1'b0;
            if (writing && byteEdge)
                taken_q <= 1'b1;
            else if (wrDat)
                taken_q <= 1'b0;
            if (writing && byteEdge && posCounter_q != 2'h0 && !(^hold_q))
                parErr_q <= 1'b1;
            else if (wrStat && wrData[`ST_PARERR])
                parErr_q <= 1'b0;
        end
    end

    // Read data mux, answered the cycle after the strobe
    logic [31:0] rdMux;
    always_comb begin
        if (addr == `ADDR_CTRL)
            rdMux = {29'h0, ctrl_q};
        else if (addr == `ADDR_DATA)
            rdMux = {24'h0, readByte_q};
        else if (addr == `ADDR_STAT)
            rdMux = {23'h0, writeClockGate_q, readClockGate_q, onesReset_q, zeroCount_q,
                     clockGap, dataGap, parErr_q, taken_q, found_q};
        else
            rdMux = 32'h0;
    end

    always_ff @(posedge mclk) begin
        if (!resetn)
            rdData_q <= 32'h0;
        else if (rdStrobe)
            rdData_q <= rdMux;
        else
            rdData_q <= 32'h0;
    end

    // Write oscillator, write trigger and X/Y phases never stop
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            oscCnt_q <= 4'h0;
            writeTrig_q <= 1'b0;
        end else begin
            oscCnt_q <= oscTick ? 4'h0 : oscCnt_q + 4'h1;
            if (oscTick)
                writeTrig_q <= !writeTrig_q;
        end
    end

    // Write gate single shot delays the write clock gate
    always_ff @(posedge mclk) begin
        if (!resetn || !writeGate) begin
            wrGatePrev_q <= 1'b0;
            gateDelay_q <= 6'h0;
            writeClockGate_q <= 1'b0;
        end else begin
            wrGatePrev_q <= 1'b1;
            if (wrGateRise)
                gateDelay_q <= 6'(`GATE_DELAY_CYC - 1);
            else if (gateDelay_q != 6'h0)
                gateDelay_q <= gateDelay_q - 6'h1;
            else if (wrGatePrev_q)
                writeClockGate_q <= 1'b1;
        end
    end

    // Four-position counter takes its first step before any parity check
    always_ff @(posedge mclk) begin
        if (!resetn || !writeGate)
            posCounter_q <= 2'h0;
        else if (writing && !allowY_q && phaseX)
            posCounter_q <= posCounter_q + 2'h1;
    end

    // Ring reset pulse fires as both clock gates fall idle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ringCondPrev_q <= 1'b1;
            ringPulseCnt_q <= 4'h0;
        end else begin
            ringCondPrev_q <= ringCond;
            if (ringCond && !ringCondPrev_q)
                ringPulseCnt_q <= 4'(`RING_PULSE_CYC);
            else if (ringPulseCnt_q != 4'h0)
                ringPulseCnt_q <= ringPulseCnt_q - 4'h1;
        end
    end

    // Primary and secondary rings
    always_ff @(posedge mclk) begin
        if (!resetn || ringReset) begin
            ringLive_q <= 1'b0;
            ringPos_q <= 3'h0;
            deltaPos_q <= `RING_START;
            allowY_q <= 1'b0;
        end else begin
            if (advX) begin
                ringPos_q <= nextPos;
                ringLive_q <= 1'b1;
                allowY_q <= 1'b1;
            end
            if (advY)
                deltaPos_q <= ringPos_q;
        end
    end

    // Shared data register: loaded for writing, filled when reading
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fdr_q <= 8'h00;
            readByte_q <= 8'h00;
        end else if (writing) begin
            if (byteEdge || (advX && !ringLive_q))
                fdr_q <= hold_q[7:0];
        end else if (readClockGate_q && advX) begin
            if (byteEdge) begin
                readByte_q <= fdr_q;
                fdr_q <= {7'h0, dataSeen_q};
            end else begin
                fdr_q[nextPos] <= dataSeen_q;
            end
        end
    end

    // Double-frequency output: clock on X, data on permitted Y
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            writePulse_q <= 1'b0;
            writeEnable_q <= 1'b0;
        end else begin
            writeEnable_q <= writing;
            writePulse_q <= writing && ((phaseX && clkAllowed) ||
                (advY && ringLive_q && fdr_q[ringPos_q]));
        end
    end

    // Two flip-flops ahead of any use of the read pulse pin
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
            pinPrev_q <= 1'b0;
        end else begin
            pinMeta_q <= readPulsePin;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    // Tracker start sequence; write gate or dropped read gate stops it
    always_ff @(posedge mclk) begin
        if (!resetn || !readGate || writeGate) begin
            trk_q <= TRK_IDLE;
            trkReset_q <= 6'h0;
        end else begin
            case (trk_q)
                TRK_IDLE: begin
                    trk_q <= TRK_RESET;
                    trkReset_q <= 6'(`GATE_DELAY_CYC - 1);
                end
                TRK_RESET: begin
                    if (trkReset_q == 6'h0)
                        trk_q <= TRK_WAIT;
                    else
                        trkReset_q <= trkReset_q - 6'h1;
                end
                TRK_WAIT: begin
                    if (rdEdge)
                        trk_q <= TRK_RUN;
                end
                default: trk_q <= TRK_RUN;
            endcase
        end
    end

    // Digital phase tracker: nudges toward mid-window on each pulse
    always_ff @(posedge mclk) begin
        if (!resetn || !trkRun) begin
            phase_q <= 4'(`OSC_CYC / 2);
            win_q <= WIN_CLOCK;
            dataSeen_q <= 1'b0;
        end else begin
            if (phWrap) begin
                phase_q <= 4'h0;
                win_q <= win_q == WIN_CLOCK ? WIN_DATA : WIN_CLOCK;
            end else if (rdEdge && phase_q < 4'(`OSC_CYC / 2 - 1)) begin
                phase_q <= phase_q + 4'h2;
            end else if (!(rdEdge && phase_q > 4'(`OSC_CYC / 2))) begin
                phase_q <= phase_q + 4'h1;
            end
            if (cellEnd)
                dataSeen_q <= 1'b0;
            else if (sepData)
                dataSeen_q <= 1'b1;
        end
    end

    // Zeros detector: counts raw pulses per window, clock or data alike
    always_ff @(posedge mclk) begin
        if (!resetn || !readGate) begin
            zwinCnt_q <= 5'h0;
            zpulses_q <= 2'h0;
            zeroCount_q <= 1'b0;
            onesReset_q <= 1'b0;
        end else begin
            zeroCount_q <= 1'b0;
            if (zwinCnt_q == 5'(`ZERO_WIN_CYC - 1)) begin
                zwinCnt_q <= 5'h0;
                zpulses_q <= {1'b0, rdEdge};
                if (zpulses_q == 2'h1 && !rdEdge) begin
                    zeroCount_q <= 1'b1;
                    onesReset_q <= 1'b0;
                end else if (zpulses_q != 2'h0) begin
                    onesReset_q <= 1'b1;
                end
            end else begin
                zwinCnt_q <= zwinCnt_q + 5'h1;
                if (rdEdge && zpulses_q != 2'h2)
                    zpulses_q <= zpulses_q + 2'h1;
            end
        end
    end

    // Marker hunt: clock gap seen, then data gap marks the sync byte
    always_ff @(posedge mclk) begin
        if (!resetn || !readGate || writeGate) begin
            searchActive_q <= 1'b0;
            markerSeen_q <= 1'b0;
            dataGood_q <= 1'b0;
            readClockGate_q <= 1'b0;
        end else begin
            searchActive_q <= markerSearch && !dataGood_q;
            if (markerSearch && clockGap)
                markerSeen_q <= 1'b1;
            else if (onesReset_q && !readClockGate_q)
                markerSeen_q <= 1'b0;
            if (dataGap && (!markerSearch || markerSeen_q))
                dataGood_q <= 1'b1;
            if (dataGood_q && sepData)
                readClockGate_q <= 1'b1;
        end
    end

    // Gap sensors on the separated streams
    gap_timer #(.LIMIT(7'(`DATA_GAP_CYC))) dataGapTimer (
        .mclk(mclk),
        .resetn(resetn),
        .run(trkRun),
        .hit(sepData),
        .gap(dataGap)
    );

    gap_timer #(.LIMIT(7'(`CLOCK_GAP_CYC))) clockGapTimer (
        .mclk(mclk),
        .resetn(resetn),
        .run(trkRun),
        .hit(sepClock),
        .gap(clockGap)
    );
endmodule // disk_converter

// ---- design/gap_timer.sv ----
// Saturating absence timer for one separated pulse stream
`timescale 1ns/10ps
module gap_timer #(
    parameter logic [6:0] LIMIT = 7'h3c
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic run,
    input wire logic hit,
    output logic gap
);
    logic [6:0] count_q;

    // Gap rises once LIMIT cycles pass with no hit
    always_ff @(posedge mclk) begin
        if (!resetn || !run || hit) begin
            count_q <= 7'h00;
            gap <= 1'b0;
        end else if (count_q == LIMIT - 7'h01) begin
            gap <= 1'b1;
        end else begin
            count_q <= count_q + 7'h01;
        end
    end
endmodule // gap_timer

// ---- sim/disk_converter_chk.sv ----
// Port-level assertions for the converter, bound into the design
`timescale 1ns/10ps
`include "conv_consts.svh"
module disk_converter_chk
    import conv_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [31:0] rdData_q,
    input wire logic readPulsePin,
    input wire logic writePulse_q,
    input wire logic writeEnable_q
);
    logic [2:0] ctrl_q;
    logic [6:0] gateAge_q;
    wire logic ctrlWrite = wrStrobe && addr == `ADDR_CTRL;
    wire logic writeGate = ctrl_q[1];
    wire logic markerMode = ctrl_q[2];
    wire logic statRead = rdStrobe && addr == `ADDR_STAT;
    wire logic mapped = addr == `ADDR_CTRL || addr == `ADDR_DATA || addr == `ADDR_STAT;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Shadow of the control lines, taken from bus writes only
    always_ff @(posedge mclk) begin
        if (!resetn) ctrl_q <= 3'h0;
        else if (ctrlWrite) ctrl_q <= wrData[2:0];
    end

    // Age of the write gate; saturates so long writes stay legal
    always_ff @(posedge mclk) begin
        if (!resetn || !writeGate) gateAge_q <= 7'h0;
        else if (gateAge_q != 7'h7f) gateAge_q <= gateAge_q + 7'h1;
    end

    property p_reset_quiet;
        $rose(resetn) |-> rdData_q == 32'h0 && !writePulse_q && !writeEnable_q;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");

    property p_read_slot;
        !$past(rdStrobe) |-> rdData_q == 32'h0;
    endproperty
    a_read_slot: assert property (p_read_slot) else $error("read data outside its slot");

    property p_unmapped;
        $past(rdStrobe) && !$past(mapped) |-> rdData_q == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_ctrl_back;
        $past(rdStrobe) && $past(addr) == `ADDR_CTRL
            |-> rdData_q[2:0] == $past(ctrl_q) && rdData_q[31:3] == 29'h0;
    endproperty
    a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");

    property p_gate_delay;
        writeEnable_q |-> $past(writeGate) && $past(gateAge_q) >= 7'd37;
    endproperty
    a_gate_delay: assert property (p_gate_delay) else $error("write enable too early");

    property p_gate_late;
        $rose(writeEnable_q) |-> gateAge_q <= 7'd44;
    endproperty
    a_gate_late: assert property (p_gate_late) else $error("write enable too late");

    property p_pulse_gate;
        writePulse_q |-> writeEnable_q || $past(writeEnable_q);
    endproperty
    a_pulse_gate: assert property (p_pulse_gate) else $error("pulse while not writing");

    property p_tick_space;
        writePulse_q |=> !writePulse_q [*8];
    endproperty
    a_tick_space: assert property (p_tick_space) else $error("pulses off the tick grid");

    property p_clock_cells;
        writePulse_q && !markerMode |-> ##[10:20] (writePulse_q || !writeEnable_q);
    endproperty
    a_clock_cells: assert property (p_clock_cells) else $error("clock pulse missing");

    property p_gate_status;
        $past(statRead) && $past(writeEnable_q)
            |-> rdData_q[`ST_WCG] && !rdData_q[`ST_RCG];
    endproperty
    a_gate_status: assert property (p_gate_status) else $error("gate status wrong");
endmodule // disk_converter_chk

bind disk_converter disk_converter_chk u_chk (
    .mclk(mclk),
    .resetn(resetn),
    .addr(addr),
    .wrData(wrData),
    .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe),
    .rdData_q(rdData_q),
    .readPulsePin(readPulsePin),
    .writePulse_q(writePulse_q),
    .writeEnable_q(writeEnable_q)
);

// ---- sim/disk_serializer_deserializer_test.sv ----
// Self-checking bench: bus tasks, status polling and write pulse counts
`timescale 1ns/10ps
`include "conv_consts.svh"
module disk_serializer_deserializer_test
    import conv_pkg::*;
;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wrData = 32'h0;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [31:0] rdData_q;
    logic readPulsePin;
    logic writePulse_q;
    logic writeEnable_q;
    logic driveRun = 1'b0;
    logic [7:0] drivePattern = 8'h00;
    logic readPending = 1'b0;
    logic [31:0] lastRead = 32'h0;
    logic [31:0] expQ[$];
    logic [31:0] maskQ[$];
    int badCount = 0;
    int testsRun = 0;
    int cycles = 0;
    int pulseCount = 0;
    int seed = 32'h27519dab;

    always #20 mclk = ~mclk;

    disk_converter u_dut (
        .mclk(mclk),
        .resetn(resetn),
        .addr(addr),
        .wrData(wrData),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe),
        .rdData_q(rdData_q),
        .readPulsePin(readPulsePin),
        .writePulse_q(writePulse_q),
        .writeEnable_q(writeEnable_q)
    );

    drive_model u_drive (
        .run(driveRun),
        .pattern(drivePattern),
        .readPulsePin(readPulsePin)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        testsRun++;
        if (seen !== expected) begin
            badCount++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expected);
        end
    endtask

    task automatic results;
        if (badCount == 0 && testsRun > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic idle(input int n);
        wrStrobe <= 1'b0;
        rdStrobe <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask

    task automatic busWrite(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        rdStrobe <= 1'b0;
        @(posedge mclk);
    endtask

    // Expectation is noted when the read is issued, judged when data stands
    task automatic busRead(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(e);
        maskQ.push_back(m);
        addr <= a;
        rdStrobe <= 1'b1;
        wrStrobe <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic waitStat(input int b, input logic v, input int limit);
        for (int i = 0; i < limit; i++) begin
            busRead(`ADDR_STAT, 32'h0, 32'h0);
            idle(2);
            if (lastRead[b] === v) break;
        end
    endtask

    // Hand over the next byte each time the previous one is taken
    task automatic feed(input logic [31:0] w, input int n);
        repeat (n) begin
            waitStat(`ST_TAKEN, 1'b1, 100);
            busWrite(`ADDR_DATA, w);
        end
    endtask

    task automatic countPulses(input int n);
        pulseCount = 0;
        repeat (n) begin
            @(posedge mclk);
            if (writePulse_q === 1'b1) pulseCount++;
        end
    endtask

    // Scoreboard: oldest note against the answer in its one valid cycle
    always @(posedge mclk) begin
        readPending <= rdStrobe;
        if (readPending) begin
            if (maskQ[0] != 32'h0) check(rdData_q & maskQ[0], expQ[0] & maskQ[0]);
            lastRead = rdData_q;
            void'(expQ.pop_front());
            void'(maskQ.pop_front());
        end
    end

    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            results();
        end
    end

    initial begin
        logic [7:0] b;
        logic [31:0] good;
        b = $random(seed);
        good = {23'h0, ~^b, b};
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        // Reset values, unmapped places, control line readback
        busRead(`ADDR_CTRL, 32'h0, 32'hffffffff);
        busRead(4'(($random(seed) & 32'hf) | 32'h1), 32'h0, 32'hffffffff);
        for (int i = 0; i < 8; i++) begin
            busWrite(`ADDR_CTRL, 32'(i));
            busRead(`ADDR_CTRL, 32'(i), 32'hffffffff);
        end
        busWrite(`ADDR_CTRL, 32'h0);
        idle(20);
        // Plain write: delayed clock gate, then clock plus data per cell
        busWrite(`ADDR_DATA, good);
        busWrite(`ADDR_CTRL, 32'h2);
        idle(30);
        busRead(`ADDR_STAT, 32'h0, 32'h100);
        feed(good, 3);
        busRead(`ADDR_STAT, 32'h100, 32'h180);
        fork
            countPulses(320);
            feed(good, 3);
        join
        check(32'(pulseCount), 32'(16 + 2 * $countones(b)));
        // Marker bytes drop clocks; gate restarts so no cell straddles both modes
        busWrite(`ADDR_CTRL, 32'h0);
        idle(4);
        busWrite(`ADDR_CTRL, 32'h6);
        feed(good, 3);
        fork
            countPulses(320);
            feed(good, 3);
        join
        check(32'(pulseCount),
            32'(2 * $countones(`MARKER_CLOCK_MASK) + 2 * $countones(b)));
        // Bad parity flagged, clears, and stays clear on good bytes
        busWrite(`ADDR_CTRL, 32'h2);
        feed(good ^ 32'h100, 1);
        feed(good, 2);
        busRead(`ADDR_STAT, 32'h4, 32'h4);
        busWrite(`ADDR_STAT, 32'h4);
        feed(good, 2);
        busRead(`ADDR_STAT, 32'h0, 32'h4);
        busWrite(`ADDR_CTRL, 32'h0);
        idle(40);
        // Read: clocks only gives a data gap, data opens the read clock gate
        drivePattern <= 8'h00;
        driveRun <= 1'b1;
        busWrite(`ADDR_CTRL, 32'h1);
        idle(300);
        busRead(`ADDR_STAT, 32'h8, 32'h18);
        drivePattern <= b | 8'h55;
        idle(200);
        busRead(`ADDR_STAT, 32'h81, 32'h99);
        driveRun <= 1'b0;
        idle(120);
        busRead(`ADDR_STAT, 32'h18, 32'h18);
        // Reset in mid-run clears the control lines
        resetn <= 1'b0;
        idle(8);
        resetn <= 1'b1;
        idle(1);
        busRead(`ADDR_CTRL, 32'h0, 32'hffffffff);
        idle(4);
        results();
    end
endmodule // disk_serializer_deserializer_test

// ---- sim/drive_model.sv ----
// Behavioural drive read channel: clock then optional data pulse each cell
`timescale 1ns/10ps
module drive_model (
    input wire logic run,
    input wire logic [7:0] pattern,
    output logic readPulsePin
);
    logic linkClk;
    logic dataHalf;
    int bitIdx;

    // Idle line low; no pulse means no flux change
    initial begin
        readPulsePin = 1'b0;
        linkClk = 1'b0;
        dataHalf = 1'b0;
        bitIdx = 0;
    end

    // Half-cell clock of 400 ns to match the nominal cell, still outside a frame
    always begin
        wait (run);
        #200 linkClk = ~linkClk;
    end

    // Clock half always pulses, data half only for a one bit
    always @(posedge linkClk) begin
        if (!dataHalf || pattern[bitIdx]) begin
            readPulsePin = 1'b1;
            #100 readPulsePin = 1'b0;
        end
        if (dataHalf) bitIdx = (bitIdx + 1) % 8;
        dataHalf = !dataHalf;
    end
endmodule // drive_model
